// ---- src/aits_pkg.sv ----
// Shared constants and types for the trigger and acquisition sequencer.
package aits_pkg;

    // Dataflow selections.
    localparam logic [1:0] MODE_POST = 2'h0;
    localparam logic [1:0] MODE_PRE = 2'h1;
    localparam logic [1:0] MODE_ABOUT = 2'h2;

    // Widths of the list index, multiscan count, counters and samples.
    localparam int CGL_W = 10;
    localparam int SCAN_W = 9;
    localparam int CNT_W = 24;
    localparam int DATA_W = 16;

    localparam logic [CGL_W-1:0] CGL_FIRST = 10'h000;
    localparam logic [SCAN_W-1:0] SCAN_ZERO = 9'h000;
    localparam logic [SCAN_W-1:0] SCAN_ONE = 9'h001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h00_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h00_0001;

    // Sequencer states, one-hot.
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WAIT_TRIG = 4'h2,
        ST_SCAN = 4'h4,
        ST_WAIT_RETRIG = 4'h8
    } aits_state_t;

endpackage : aits_pkg

// ---- src/aits_edge_sync.sv ----
// Two-flop synchroniser and single-cycle edge detector for the trigger pin.
`timescale 1ns/1ps
module aits_edge_sync
    import aits_pkg::*;
(
    input wire logic clk_sys, // System clock.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic pinIn, // Raw asynchronous trigger pin.
    input wire logic risingSel, // High selects rising edges, low falling.
    output logic edgeEvent // One-cycle pulse per qualifying edge.
);

    logic syncA_reg;
    logic syncB_reg;
    logic prev_reg;
    logic edgeEvent_reg;
    logic edgeNext;

    // The first flop feeds only the second; edges are taken from the second.
    always_comb begin
        if (risingSel) begin
            edgeNext = syncB_reg & ~prev_reg;
        end else begin
            edgeNext = ~syncB_reg & prev_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            syncA_reg <= 1'b0;
            syncB_reg <= 1'b0;
            prev_reg <= 1'b0;
            edgeEvent_reg <= 1'b0;
        end else begin
            syncA_reg <= pinIn;
            syncB_reg <= syncA_reg;
            prev_reg <= syncB_reg;
            edgeEvent_reg <= edgeNext;
        end
    end

    assign edgeEvent = edgeEvent_reg;

endmodule : aits_edge_sync

// ---- src/aits_retrig_timer.sv ----
// Internal retrigger clock: periodic one-cycle tick while running.
`timescale 1ns/1ps
module aits_retrig_timer
    import aits_pkg::*;
(
    input wire logic clk_sys, // System clock.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic run, // Timer counts while high.
    input wire logic restart, // Reload the period, phase restarts.
    input wire logic [CNT_W-1:0] period, // Retrigger period in clock cycles.
    output logic tick // One-cycle pulse each period.
);

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] countNext;
    logic tick_reg;
    logic tickNext;

    always_comb begin
        countNext = count_reg;
        tickNext = 1'b0;
        if (restart || !run) begin
            countNext = period;
        end else if (count_reg <= CNT_ONE) begin
            countNext = period;
            tickNext = 1'b1;
        end else begin
            countNext = count_reg - CNT_ONE;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= CNT_ZERO;
            tick_reg <= 1'b0;
        end else begin
            count_reg <= countNext;
            tick_reg <= tickNext;
        end
    end

    assign tick = tick_reg;

endmodule : aits_retrig_timer

// ---- src/aits_seq.sv ----
// Analog-input trigger and acquisition sequencer, top level.
//
// Behaviour
// - The host start command is the software trigger and launches conversions.
// - External trigger event on the configured rising or falling edge.
// - Three modes: post-trigger, pre-trigger and about-trigger.
// - Post-trigger source is selectable: software start or external edge.
// - Post mode starts on post-trigger event, ends at sample count or stop.
// - Untriggered scan: one sample per clock pulse, list wraps, runs until the acquisition ends.
// - Triggered scan: multiscan passes per trigger, then wait for retrigger.
// - Post mode with triggered scan keeps acquiring, bursts started by retrigger.
// - Pre mode runs from start to post event; that sample is ignorable.
// - Pre mode with internal retrigger repeats bursts, halts on post event.
// - About mode starts as pre data, switches to post tagging on event.
// - About mode ends at post sample count or host stop.
// - About mode event mid-burst finishes burst as post; later bursts post.
// - Output samples are offset binary.
// - Multiscan count accepts values up to 256.
// - External retrigger edges during a burst are ignored.
// - Internal flags mark each sample pre or post, outside the data word.
`timescale 1ns/1ps
module aits_seq
    import aits_pkg::*;
(
    input wire logic clk_sys, // System clock, 10 MHz.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic startCmd, // Host start pulse, the software trigger.
    input wire logic stopCmd, // Host stop pulse.
    input wire logic [1:0] dataflowMode, // Post, pre or about trigger.
    input wire logic postTrigSrcExt, // Post-trigger source: 1 external edge, 0 software.
    input wire logic trigRisingEdge, // External edge polarity: 1 rising, 0 falling.
    input wire logic trigScanEn, // Triggered scan enable.
    input wire logic retrigExt, // Retrigger source: 1 external edge, 0 internal.
    input wire logic [SCAN_W-1:0] multiscanCount, // Passes per trigger, 1 to 256.
    input wire logic [CGL_W-1:0] cglLastEntry, // Index of last list entry.
    input wire logic [CNT_W-1:0] postSampleCount, // Post samples to take, 0 is unlimited.
    input wire logic [CNT_W-1:0] retrigPeriod, // Internal retrigger period in cycles.
    input wire logic sampleClk, // Sample clock pulse, same domain.
    input wire logic extTrigPin, // External TTL trigger, asynchronous.
    input wire logic adcValid, // Converter result strobe.
    input wire logic [DATA_W-1:0] adcSigned, // Converter result, two's complement.
    output logic convStart, // Pulse: start one conversion.
    output logic [CGL_W-1:0] convEntry, // List entry of that conversion.
    output logic convPost, // Flag: that conversion is post-trigger.
    output logic convIgnore, // Flag: that conversion is the ignorable one.
    output logic busy, // Acquisition in progress.
    output logic postPhase, // Post-trigger data now being taken.
    output logic sampleOutValid, // Pulse: sample word valid.
    output logic [DATA_W-1:0] sampleOut, // Sample word, offset binary.
    output logic sampleOutPost // Flag of that sample, kept beside the word.
);

    aits_state_t state_reg;
    aits_state_t stateNext;
    logic [CGL_W-1:0] cglPos_reg;
    logic [CGL_W-1:0] cglPosNext;
    logic [SCAN_W-1:0] scanCnt_reg;
    logic [SCAN_W-1:0] scanCntNext;
    logic [CNT_W-1:0] postTaken_reg;
    logic [CNT_W-1:0] postTakenNext;
    logic postPhase_reg;
    logic postPhaseNext;
    logic ignorePend_reg;
    logic ignorePendNext;
    logic convStart_reg;
    logic convStartNext;
    logic [CGL_W-1:0] convEntry_reg;
    logic [CGL_W-1:0] convEntryNext;
    logic convPost_reg;
    logic convPostNext;
    logic convIgnore_reg;
    logic convIgnoreNext;
    logic busy_reg;
    logic extEvent;
    logic timerTick;
    logic timerRestart;
    logic timerRun;
    logic retrigHit;
    logic listEnd;
    logic burstDone;
    logic countDone;
    logic prePostMode;

    ////////////////////////////////////////////////////////////////////////////
    // edge polarity
    aits_edge_sync u_edge (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pinIn(extTrigPin),
        .risingSel(trigRisingEdge),
        .edgeEvent(extEvent)
    );

    // The timer free-runs through scanning and the retrigger wait so retrigger spacing
    // does not depend on how long a burst took.
    assign timerRun = (state_reg == ST_SCAN) || (state_reg == ST_WAIT_RETRIG);

    aits_retrig_timer u_timer (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .run(timerRun),
        .restart(timerRestart),
        .period(retrigPeriod),
        .tick(timerTick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // external edge is the post source
    assign prePostMode = (dataflowMode == MODE_PRE) || (dataflowMode == MODE_ABOUT);
    // external retrigger assumed only in post mode
    assign retrigHit = retrigExt ? extEvent : timerTick;
    assign listEnd = (cglPos_reg == cglLastEntry);
    assign burstDone = trigScanEn && listEnd && ((scanCnt_reg + SCAN_ONE) == multiscanCount);
    assign countDone = (postSampleCount != CNT_ZERO) && ((postTaken_reg + CNT_ONE) == postSampleCount);

    always_comb begin
        stateNext = state_reg;
        cglPosNext = cglPos_reg;
        scanCntNext = scanCnt_reg;
        postTakenNext = postTaken_reg;
        postPhaseNext = postPhase_reg;
        ignorePendNext = ignorePend_reg;
        convStartNext = 1'b0;
        convEntryNext = convEntry_reg;
        convPostNext = convPost_reg;
        convIgnoreNext = 1'b0;
        timerRestart = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (startCmd) begin
                    cglPosNext = CGL_FIRST;
                    scanCntNext = SCAN_ZERO;
                    postTakenNext = CNT_ZERO;
                    ignorePendNext = 1'b0;
                    if (prePostMode) begin
                        stateNext = ST_SCAN;
                        postPhaseNext = 1'b0;
                        timerRestart = 1'b1;
                    end else if (postTrigSrcExt) begin
                        stateNext = ST_WAIT_TRIG;
                        postPhaseNext = 1'b0;
                    end else begin
                        stateNext = ST_SCAN;
                        postPhaseNext = 1'b1;
                        timerRestart = 1'b1;
                    end
                end
            end
            ST_WAIT_TRIG: begin
                if (extEvent) begin
                    stateNext = ST_SCAN;
                    postPhaseNext = 1'b1;
                    timerRestart = 1'b1;
                end
            end
            ST_SCAN: begin
                if (prePostMode && !postPhase_reg && extEvent) begin
                    if (dataflowMode == MODE_PRE) begin
                        ignorePendNext = 1'b1;
                    end else begin
                        postPhaseNext = 1'b1;
                    end
                end
                if (sampleClk) begin
                    convStartNext = 1'b1;
                    convEntryNext = cglPos_reg;
                    convPostNext = postPhase_reg || ignorePend_reg;
                    if (ignorePend_reg) begin
                        convIgnoreNext = 1'b1;
                        ignorePendNext = 1'b0;
                        stateNext = ST_IDLE;
                    end else begin
                        cglPosNext = listEnd ? CGL_FIRST : cglPos_reg + 10'h001;
                        if (listEnd && trigScanEn) begin
                            scanCntNext = scanCnt_reg + SCAN_ONE;
                        end
                        if (postPhase_reg) begin
                            postTakenNext = postTaken_reg + CNT_ONE;
                        end
                        if (postPhase_reg && countDone) begin
                            stateNext = ST_IDLE;
                        end else if (burstDone) begin
                            stateNext = ST_WAIT_RETRIG;
                        end
                    end
                end
            end
            ST_WAIT_RETRIG: begin
                if (prePostMode && !postPhase_reg && extEvent) begin
                    if (dataflowMode == MODE_PRE) begin
                        stateNext = ST_IDLE;
                    end else begin
                        postPhaseNext = 1'b1;
                    end
                end else if (retrigHit) begin
                    stateNext = ST_SCAN;
                    cglPosNext = CGL_FIRST;
                    scanCntNext = SCAN_ZERO;
                end
            end
            default: begin
                stateNext = ST_IDLE;
            end
        endcase
        if (stopCmd) begin
            stateNext = ST_IDLE;
            ignorePendNext = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            cglPos_reg <= CGL_FIRST;
            scanCnt_reg <= SCAN_ZERO;
            postTaken_reg <= CNT_ZERO;
            postPhase_reg <= 1'b0;
            ignorePend_reg <= 1'b0;
            convStart_reg <= 1'b0;
            convEntry_reg <= CGL_FIRST;
            convPost_reg <= 1'b0;
            convIgnore_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= stateNext;
            cglPos_reg <= cglPosNext;
            scanCnt_reg <= scanCntNext;
            postTaken_reg <= postTakenNext;
            postPhase_reg <= postPhaseNext;
            ignorePend_reg <= ignorePendNext;
            convStart_reg <= convStartNext;
            convEntry_reg <= convEntryNext;
            convPost_reg <= convPostNext;
            convIgnore_reg <= convIgnoreNext;
            busy_reg <= (stateNext != ST_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The flag stays beside the word rather than inside it, so the data word
    // holds only the converter code, turned to offset binary.
    logic [DATA_W-1:0] sampleOut_reg;
    logic [DATA_W-1:0] sampleOutNext;
    logic sampleOutValid_reg;
    logic sampleOutPost_reg;
    logic sampleOutPostNext;

    always_comb begin
        sampleOutNext = sampleOut_reg;
        sampleOutPostNext = sampleOutPost_reg;
        if (adcValid) begin
            sampleOutNext = {~adcSigned[DATA_W-1], adcSigned[DATA_W-2:0]};
            sampleOutPostNext = convPost_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sampleOut_reg <= 16'h0000;
            sampleOutValid_reg <= 1'b0;
            sampleOutPost_reg <= 1'b0;
        end else begin
            sampleOut_reg <= sampleOutNext;
            sampleOutValid_reg <= adcValid;
            sampleOutPost_reg <= sampleOutPostNext;
        end
    end

    assign convStart = convStart_reg;
    assign convEntry = convEntry_reg;
    assign convPost = convPost_reg;
    assign convIgnore = convIgnore_reg;
    assign busy = busy_reg;
    assign postPhase = postPhase_reg;
    assign sampleOut = sampleOut_reg;
    assign sampleOutValid = sampleOutValid_reg;
    assign sampleOutPost = sampleOutPost_reg;

    ////////////////////////////////////////////////////////////////////////////
    property p_sw_start;
        @(posedge clk_sys) disable iff (!rst_b)
        (state_reg == ST_IDLE) && startCmd && !stopCmd && (dataflowMode == MODE_POST) && !postTrigSrcExt
        |=> (state_reg == ST_SCAN) && postPhase_reg && busy_reg;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("software start did not launch post scan");

    property p_edge_single;
        @(posedge clk_sys) disable iff (!rst_b)
        extEvent |=> !extEvent;
    endproperty
    a_edge_single: assert property (p_edge_single) else $error("trigger event longer than one cycle");

    property p_ext_start;
        @(posedge clk_sys) disable iff (!rst_b)
        (state_reg == ST_WAIT_TRIG) && extEvent && !stopCmd |=> (state_reg == ST_SCAN) && postPhase_reg;
    endproperty
    a_ext_start: assert property (p_ext_start) else $error("external trigger did not start scan");

    property p_stop;
        @(posedge clk_sys) disable iff (!rst_b)
        stopCmd |=> (state_reg == ST_IDLE) && !busy_reg;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not end acquisition");

    property p_wrap;
        @(posedge clk_sys) disable iff (!rst_b)
        (state_reg == ST_SCAN) && sampleClk && listEnd && !ignorePend_reg |=> (cglPos_reg == CGL_FIRST)
        && convStart_reg && (convEntry_reg == cglLastEntry);
    endproperty
    a_wrap: assert property (p_wrap) else $error("list did not wrap to first entry");

    property p_burst;
        @(posedge clk_sys) disable iff (!rst_b)
        (state_reg == ST_SCAN) && sampleClk && burstDone && !ignorePend_reg && !stopCmd
        && !(postPhase_reg && countDone) |=> (state_reg == ST_WAIT_RETRIG) && convStart_reg && busy_reg;
    endproperty
    a_burst: assert property (p_burst) else $error("burst did not end after multiscan passes");

    property p_ignore_busy;
        @(posedge clk_sys) disable iff (!rst_b)
        (state_reg == ST_SCAN) && extEvent && !sampleClk && !stopCmd |=> $stable(scanCnt_reg) && $stable(cglPos_reg);
    endproperty
    a_ignore_busy: assert property (p_ignore_busy) else $error("edge during burst disturbed scan");

    property p_pre_halt;
        @(posedge clk_sys) disable iff (!rst_b)
        (state_reg == ST_WAIT_RETRIG) && (dataflowMode == MODE_PRE) && !postPhase_reg && extEvent
        |=> (state_reg == ST_IDLE) && !busy_reg;
    endproperty
    a_pre_halt: assert property (p_pre_halt) else $error("pre mode did not halt on post event");

    property p_pre_ignore;
        @(posedge clk_sys) disable iff (!rst_b)
        convStart_reg && convIgnore_reg |-> (state_reg == ST_IDLE) && convPost_reg;
    endproperty
    a_pre_ignore: assert property (p_pre_ignore) else $error("ignorable sample not final");

    property p_about_switch;
        @(posedge clk_sys) disable iff (!rst_b)
        (dataflowMode == MODE_ABOUT) && !postPhase_reg && extEvent && !stopCmd
        && ((state_reg == ST_SCAN) || (state_reg == ST_WAIT_RETRIG)) |=> postPhase_reg;
    endproperty
    a_about_switch: assert property (p_about_switch) else $error("about mode did not switch to post");

    property p_offset;
        @(posedge clk_sys) disable iff (!rst_b)
        adcValid |=> sampleOutValid_reg && (sampleOut_reg == ($past(adcSigned) ^ 16'h8000));
    endproperty
    a_offset: assert property (p_offset) else $error("sample not offset binary");

endmodule : aits_seq

// ---- tb/aits_far_model.sv ----
// Far-side model: the external TTL trigger source and the converter that answers each conversion.
`timescale 1ns/1ps
module aits_far_model
    import aits_pkg::*;
(
    input wire logic clk_sys, // System clock.
    input wire logic rst_b, // Reset, active low.
    input wire logic trigLevel, // Level the trigger source is asked to show.
    input wire logic convStart, // Conversion request from the sequencer.
    output logic extTrigPin, // TTL trigger pin.
    output logic adcValid, // Result strobe.
    output logic [DATA_W-1:0] adcSigned // Result code, two's complement.
);
    integer seed = 32'h43a2_a06a;
    logic [1:0] pend;
    // skewed pin edge
    // The pin moves off the clock grid so the synchroniser sees a truly asynchronous edge.
    assign #37 extTrigPin = trigLevel;
    // Between results the code is inverted every cycle, so a stale word never looks valid.
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pend <= 2'b00;
            adcValid <= 1'b0;
            adcSigned <= 16'h0000;
        end else begin
            pend <= {pend[0], convStart};
            adcValid <= pend[1];
            adcSigned <= pend[1] ? DATA_W'($random(seed)) : ~adcSigned;
        end
    end
endmodule : aits_far_model

// ---- tb/tb_top.sv ----
// Self-checking testbench of the trigger and acquisition sequencer.
`timescale 1ns/1ps
module tb_top
    import aits_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic startCmd = 1'b0;
    logic stopCmd = 1'b0;
    logic [1:0] dataflowMode = MODE_POST;
    logic postTrigSrcExt = 1'b0;
    logic trigRisingEdge = 1'b1;
    logic trigScanEn = 1'b0;
    logic retrigExt = 1'b1;
    logic [SCAN_W-1:0] multiscanCount = 9'h002;
    logic [CGL_W-1:0] cglLastEntry = 10'h002;
    logic [CNT_W-1:0] postSampleCount = 24'h00_0005;
    logic [CNT_W-1:0] retrigPeriod = 24'h00_0040;
    logic sampleClk = 1'b0;
    logic trigLevel = 1'b0;
    logic extTrigPin, adcValid, convStart, convPost, convIgnore, busy, postPhase, sampleOutValid, sampleOutPost;
    logic [DATA_W-1:0] adcSigned, sampleOut;
    logic [CGL_W-1:0] convEntry;
    logic [11:0] convQ[$];
    logic [16:0] dataQ[$];
    logic lastPost = 1'b0;
    int n_errors = 0;
    int check_count = 0;

    always #50 clk_sys = ~clk_sys;

    aits_seq i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .startCmd(startCmd), .stopCmd(stopCmd),
        .dataflowMode(dataflowMode), .postTrigSrcExt(postTrigSrcExt), .trigRisingEdge(trigRisingEdge),
        .trigScanEn(trigScanEn), .retrigExt(retrigExt), .multiscanCount(multiscanCount),
        .cglLastEntry(cglLastEntry), .postSampleCount(postSampleCount), .retrigPeriod(retrigPeriod),
        .sampleClk(sampleClk), .extTrigPin(extTrigPin), .adcValid(adcValid), .adcSigned(adcSigned),
        .convStart(convStart), .convEntry(convEntry), .convPost(convPost), .convIgnore(convIgnore),
        .busy(busy), .postPhase(postPhase), .sampleOutValid(sampleOutValid), .sampleOut(sampleOut),
        .sampleOutPost(sampleOutPost));

    aits_far_model i_far (.clk_sys(clk_sys), .rst_b(rst_b), .trigLevel(trigLevel), .convStart(convStart),
        .extTrigPin(extTrigPin), .adcValid(adcValid), .adcSigned(adcSigned));

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    task automatic check(string what, logic [23:0] exp, logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // The flag of a conversion is remembered so that its result can be paired with it.
    task automatic check_conv(logic [11:0] exp);
        lastPost = exp[10];
        check("conv", 24'(exp), 24'({convIgnore, convPost, convEntry}));
    endtask : check_conv

    task automatic check_sample(logic [16:0] exp);
        check("sample", 24'(exp), 24'({sampleOutPost, sampleOut}));
    endtask : check_sample

    task automatic tick(int n = 1);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
        tick(3);
    endtask : pulse

    // One sample clock pulse; a conversion is noted only where one must follow.
    task automatic smp(int ent, logic post, logic ign, bit take);
        sampleClk = 1'b1;
        if (take)
            convQ.push_back({ign, post, 10'(ent)});
        tick();
        sampleClk = 1'b0;
        tick(3);
    endtask : smp

    task automatic trig(logic lvl);
        trigLevel = lvl;
        tick(8);
    endtask : trig

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        if (rst_b === 1'b1 && convStart === 1'b1)
            check_conv(convQ.size() ? convQ.pop_front() : 12'hfff);
        if (rst_b === 1'b1 && sampleOutValid === 1'b1)
            check_sample(dataQ.size() ? dataQ.pop_front() : ~{sampleOutPost, sampleOut});
        if (rst_b === 1'b1 && adcValid === 1'b1)
            dataQ.push_back({lastPost, adcSigned ^ 16'h8000});
    end

    initial begin
        #1_000_000;
        n_errors++;
        finish_test();
    end

    initial begin
        tick(3);
        rst_b = 1'b1;
        tick();
        pulse(startCmd);
        check("busy", 1, busy);
        for (int i = 0; i < 7; i++)
            smp(i % 3, 1, 0, i < 5);
        check("busy", 0, busy);
        postTrigSrcExt = 1'b1;
        trigScanEn = 1'b1;
        cglLastEntry = 10'h001;
        postSampleCount = 24'h00_0000;
        pulse(startCmd);
        smp(0, 1, 0, 0);
        trig(1'b1);
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 4; i++) begin
                if (i == 2 && b == 0) begin
                    trig(1'b0);
                    trig(1'b1);
                end
                smp(i % 2, 1, 0, 1);
            end
            smp(0, 1, 0, 0);
            trig(1'b0);
            trig(1'b1);
        end
        pulse(stopCmd);
        multiscanCount = 9'h100;
        cglLastEntry = 10'h000;
        postTrigSrcExt = 1'b0;
        pulse(startCmd);
        for (int i = 0; i < 257; i++)
            smp(0, 1, 0, i < 256);
        pulse(stopCmd);
        check("busy", 0, busy);
        trigScanEn = 1'b0;
        postTrigSrcExt = 1'b1;
        dataflowMode = MODE_PRE;
        cglLastEntry = 10'h002;
        pulse(startCmd);
        for (int i = 0; i < 4; i++)
            smp(i % 3, 0, 0, 1);
        trig(1'b0);
        trig(1'b1);
        smp(1, 1, 1, 1);
        smp(2, 0, 0, 0);
        check("busy", 0, busy);
        dataflowMode = MODE_ABOUT;
        trigRisingEdge = 1'b0;
        cglLastEntry = 10'h001;
        postSampleCount = 24'h00_0003;
        pulse(startCmd);
        for (int i = 0; i < 3; i++)
            smp(i % 2, 0, 0, 1);
        trig(1'b0);
        check("postPhase", 1, postPhase);
        for (int i = 3; i < 7; i++)
            smp(i % 2, 1, 0, i < 6);
        check("busy", 0, busy);
        trigRisingEdge = 1'b1;
        trigScanEn = 1'b1;
        retrigExt = 1'b0;
        multiscanCount = 9'h001;
        postSampleCount = 24'h00_0000;
        pulse(startCmd);
        smp(0, 0, 0, 1);
        trig(1'b1);
        check("postPhase", 1, postPhase);
        smp(1, 1, 0, 1);
        smp(0, 1, 0, 0);
        tick(64);
        smp(0, 1, 0, 1);
        smp(1, 1, 0, 1);
        check("busy", 1, busy);
        pulse(stopCmd);
        dataflowMode = MODE_PRE;
        pulse(startCmd);
        smp(0, 0, 0, 1);
        smp(1, 0, 0, 1);
        trig(1'b0);
        trig(1'b1);
        check("busy", 0, busy);
        tick(10);
        check("pending", 0, convQ.size() + dataQ.size());
        finish_test();
    end
endmodule : tb_top
